// File: bench/fdb_flash_seq_properties.sv
`default_nettype none
module fdb_flash_seq_properties
#(
    parameter int ERASE_CYCLES_P = 20
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic chipSelect_n,
    input wire logic [7:0] status5,
    input wire logic memProtected,
    input wire logic [7:0] primaryStatusReg,
    input wire logic busyFlag,
    input wire logic writeLatch,
    input wire logic eraseStart,
    input wire fdb_pkg::fdb_erase_t eraseRegion,
    input wire fdb_pkg::fdb_read_t readSetup
);
    import fdb_pkg::*;
    int busyCount;
    logic [3:0] dummyExp;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            busyCount <= 0;
        else
            busyCount <= busyFlag ? busyCount + 1 : 0;
    end
    // codes above 4 read as 10 clocks
    assign dummyExp = (status5[6:4] > 3'h4) ? 4'hA : {status5[6:4], 1'b0} + 4'h2;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    chk_busy_bit: assert property (primaryStatusReg[BUSY_BIT] == busyFlag)
        else $error("busy bit differs");
    chk_busy_length: assert property ($fell(busyFlag) |-> busyCount == ERASE_CYCLES_P)
        else $error("busy length wrong");
    chk_start_latch: assert property (eraseStart |-> $past(writeLatch) && !$past(busyFlag))
        else $error("erase without latch");
    chk_latch_cleared: assert property (eraseStart |-> busyFlag && !writeLatch)
        else $error("latch not cleared");
    chk_start_release: assert property (eraseStart |-> $past(chipSelect_n, 3))
        else $error("start before release");
    chk_protect_block: assert property (eraseStart |-> !memProtected)
        else $error("erase while protected");
    chk_region_mask: assert property (eraseStart |=> (eraseRegion.base & ~eraseRegion.mask) == 24'h000000)
        else $error("region base unmasked");
    chk_dummy_count: assert property (readSetup.valid |-> readSetup.dummyClocks == dummyExp)
        else $error("dummy count wrong");
endmodule
`default_nettype wire

// File: bench/fdb_flash_seq_test.sv
`default_nettype none
`define CHECK(a, b) begin nCompared++; if ((a) !== (b)) begin numErrors++; \
    $display("wrong value at %0t: %h %h", $time, a, b); end end
module fdb_flash_seq_test;
    timeunit 1ns;
    timeprecision 1ps;
    import fdb_pkg::*;
    localparam int ERASE_CYCLES_P = 20;
    logic ref_clk, rst, memProtected, busyFlag, writeLatch, eraseStart, continuousReadMode;
    logic [7:0] status5, primaryStatusReg, op, md;
    logic [23:0] a, ea;
    wire sck, chipSelect_n;
    wire [3:0] ioIn;
    fdb_erase_t eraseRegion;
    fdb_read_t readSetup;
    fdb_erase_t expErase[$];
    fdb_read_t expRead[$];
    fdb_erase_t expE;
    fdb_read_t expR;
    logic [23:0] masks[3] = '{MASK_4K, MASK_32K, MASK_64K};
    logic [7:0] ops[3] = '{OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K};
    int numErrors = 0;
    int nCompared = 0;
    int seed = 32'h4e50;
    int j, code;
    logic validQ = 1'b0;
    logic cont = 1'b0;
    fdb_flash_seq #(.ERASE_CYCLES_P(ERASE_CYCLES_P)) dut (.ref_clk(ref_clk), .rst(rst), .sck(sck),
        .chipSelect_n(chipSelect_n), .ioIn(ioIn), .status5(status5), .memProtected(memProtected),
        .primaryStatusReg(primaryStatusReg), .busyFlag(busyFlag), .writeLatch(writeLatch),
        .eraseStart(eraseStart), .eraseRegion(eraseRegion), .readSetup(readSetup),
        .continuousReadMode(continuousReadMode));
    fdb_host_model host (.ref_clk(ref_clk), .sck(sck), .chipSelect_n(chipSelect_n), .ioIn(ioIn));
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // ---------------------------------------------
    // scoreboard
    // ---------------------------------------------
    always @(posedge ref_clk)
    begin
        validQ <= readSetup.valid;
        if (eraseStart === 1'b1)
        begin
            if (expErase.size() == 0)
                `CHECK(eraseStart, 1'b0)
            else
            begin
                // pop once: the macro names its operands twice
                expE = expErase.pop_front();
                `CHECK(eraseRegion, expE)
            end
        end
        if (readSetup.valid === 1'b1 && validQ !== 1'b1)
        begin
            expR = expRead.pop_front();
            `CHECK(readSetup, expR)
        end
    end
    task automatic reportAndStop();
        if (numErrors == 0 && nCompared > 0 && expErase.size() == 0 && expRead.size() == 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic erase(input logic [7:0] eop, input logic [23:0] ad, input int n, input bit we);
        if (we)
            host.frame({OP_WRITE_ENABLE, 88'h0}, 8, 99);
        if (we)
            `CHECK(primaryStatusReg, 8'h02)
        host.frame({eop, ad, 64'h0}, n, 99);
    endtask
    // polling instead of a fixed wait, bounded
    task automatic waitIdle();
        int k;
        for (k = 0; k < 100 && busyFlag !== 1'b0; k++)
            @(posedge ref_clk);
        if (k == 100)
        begin
            numErrors++;
            reportAndStop();
        end
        `CHECK(primaryStatusReg, 8'h00)
    endtask
    initial
    begin
        rst = 1'b1;
        status5 = 8'h00;
        memProtected = 1'b0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        for (j = 0; j < 3; j++)
        begin
            a = 24'($random(seed));
            expErase.push_back('{a & masks[j], masks[j]});
            erase(ops[j], a, 32, 1);
            waitIdle();
        end
        erase(OP_ERASE_4K, 24'h123456, 32, 0);
        waitIdle();
        erase(OP_ERASE_32K, 24'h00FFFF, 33, 1);
        waitIdle();
        erase(OP_ERASE_64K, 24'h000000, 24, 1);
        waitIdle();
        memProtected <= 1'b1;
        erase(OP_ERASE_4K, 24'hABCDEF, 32, 1);
        waitIdle();
        memProtected <= 1'b0;
        for (j = 0; j < 20; j++)
        begin
            code = j % 5;
            a = 24'($random(seed));
            md = j[0] ? 8'h3C : 8'hA7;
            op = (j >= 10) ? OP_QREAD_ALIGNED : OP_QREAD;
            status5 <= {1'b0, code[2:0], 3'b000, j[2]};
            ea = (op == OP_QREAD_ALIGNED || j[2]) ? {a[23:2], 2'b00} : a;
            expRead.push_back('{ea, 4'(2 * code + 2), md[7:4] == 4'hA, 1'b1});
            if (cont)
                host.frame({a, md, 64'h0}, 8 + 2 * code, 0);
            else
                host.frame({op, a, md, 56'h0}, 16 + 2 * code, 8);
            cont = (md[7:4] == 4'hA);
            `CHECK(continuousReadMode, cont)
        end
        repeat (10) @(posedge ref_clk);
        reportAndStop();
    end
endmodule
bind fdb_flash_seq fdb_flash_seq_properties #(.ERASE_CYCLES_P(ERASE_CYCLES_P)) chk (.ref_clk(ref_clk),
    .rst(rst), .chipSelect_n(chipSelect_n), .status5(status5), .memProtected(memProtected),
    .primaryStatusReg(primaryStatusReg), .busyFlag(busyFlag), .writeLatch(writeLatch),
    .eraseStart(eraseStart), .eraseRegion(eraseRegion), .readSetup(readSetup));
`default_nettype wire

// File: bench/fdb_host_model.sv
`default_nettype none
module fdb_host_model
(
    input wire logic ref_clk,
    output logic sck,
    output logic chipSelect_n,
    output logic [3:0] ioIn
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        sck = 1'b0;
        chipSelect_n = 1'b1;
        ioIn = 4'h0;
    end
    // units below qStart go on IO0 alone, the rest as nibbles; sck idles low
    task automatic frame(input logic [95:0] d, input int n, input int qStart);
        int i;
        @(posedge ref_clk);
        chipSelect_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        for (i = 0; i < n; i++)
        begin
            ioIn <= (i >= qStart) ? d[95:92] : {~ioIn[3:1], d[95]};
            d = (i >= qStart) ? d << 4 : d << 1;
            repeat (4) @(posedge ref_clk);
            sck <= 1'b1;
            repeat (4) @(posedge ref_clk);
            sck <= 1'b0;
        end
        repeat (4) @(posedge ref_clk);
        chipSelect_n <= 1'b1;
        ioIn <= ~ioIn;
        repeat (8) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// File: design/fdb_flash_seq.sv
`default_nettype none
module fdb_flash_seq
#(
    parameter int ERASE_CYCLES_P = fdb_pkg::ERASE_CYCLES
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic chipSelect_n,
    input wire logic [3:0] ioIn,
    input wire logic [7:0] status5,
    input wire logic memProtected,
    output logic [7:0] primaryStatusReg,
    output logic busyFlag,
    output logic writeLatch,
    output logic eraseStart,
    output fdb_pkg::fdb_erase_t eraseRegion,
    output fdb_pkg::fdb_read_t readSetup,
    output logic continuousReadMode
);
    import fdb_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // limitation: sck must stay below about a sixth of ref_clk,
    // since each level needs two samples to cross the flops
    // chip select and data pass the same two flops, so framing
    // and bits stay lined up without any extra alignment
    logic [5:0] syncA;
    logic [5:0] syncB;
    logic sckPrev;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            syncA <= 6'h01;
            syncB <= 6'h01;
            sckPrev <= 1'b0;
        end
        else
        begin
            syncA <= {ioIn, sck, chipSelect_n};
            syncB <= syncA;
            sckPrev <= syncB[1];
        end
    end
    logic csN;
    logic sckRise;
    logic [3:0] io;
    assign csN = syncB[0];
    assign sckRise = syncB[1] && !sckPrev && !csN;
    assign io = syncB[5:2];
    // a frame ends on the first sample after the pin's high level has passed both synchroniser flops
    logic csPrev;
    logic frameEnd;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            csPrev <= 1'b1;
        else
            csPrev <= csN;
    end
    assign frameEnd = csN && !csPrev;

    // ----------------------------------------
    // command and address shifting
    // ----------------------------------------
    typedef enum logic [2:0] {ST_OP, ST_ADDR1, ST_ADDR4, ST_MODE, ST_DUMMY, ST_DONE} fdb_state_t;
    fdb_state_t state;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] modeByte;
    logic [4:0] bitCount;
    logic [3:0] dummyLeft;
    logic quadOp;
    logic alignedOp;
    logic [3:0] dummyTotal;
    logic [2:0] dummySel;
    logic [7:0] nextOpcode;
    logic [23:0] nextAddr4;

    assign dummySel = status5[DUMMY_SEL_MSB:DUMMY_SEL_LSB];
    always_comb
    begin
        unique case (dummySel)
            3'h0: dummyTotal = 4'h2;
            3'h1: dummyTotal = 4'h4;
            3'h2: dummyTotal = 4'h6;
            3'h3: dummyTotal = 4'h8;
            3'h4: dummyTotal = 4'hA;
            // undefined codes take the longest count, which is always safe
            default: dummyTotal = 4'hA;
        endcase
    end
    assign nextOpcode = {opcode[6:0], io[0]};
    assign nextAddr4 = {addr[19:0], io};
    assign quadOp = (opcode == OP_QREAD) || (opcode == OP_QREAD_ALIGNED);
    assign alignedOp = (opcode == OP_QREAD_ALIGNED) || status5[ALIGN_BIT];

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= ST_OP;
            opcode <= 8'h00;
            addr <= 24'h000000;
            modeByte <= 8'h00;
            bitCount <= 5'h00;
            dummyLeft <= 4'h0;
        end
        else if (csN)
        begin
            state <= continuousReadMode ? ST_ADDR4 : ST_OP;
            bitCount <= 5'h00;
            if (continuousReadMode)
                opcode <= opcode;
            else
                opcode <= 8'h00;
        end
        else if (sckRise)
        begin
            unique case (state)
                ST_OP:
                begin
                    opcode <= nextOpcode;
                    bitCount <= bitCount + 5'h01;
                    if (bitCount == 5'h07)
                    begin
                        bitCount <= 5'h00;
                        if (nextOpcode == OP_QREAD || nextOpcode == OP_QREAD_ALIGNED)
                            state <= ST_ADDR4;
                        else if (nextOpcode == OP_ERASE_4K || nextOpcode == OP_ERASE_32K
                                 || nextOpcode == OP_ERASE_64K)
                            state <= ST_ADDR1;
                        else
                            state <= ST_DONE;
                    end
                end
                ST_ADDR1:
                begin
                    addr <= {addr[22:0], io[0]};
                    bitCount <= bitCount + 5'h01;
                    if (bitCount == ADDR_BITS_SINGLE - 5'h01)
                    begin
                        bitCount <= 5'h00;
                        state <= ST_DONE;
                    end
                end
                ST_ADDR4:
                begin
                    addr <= nextAddr4;
                    bitCount <= bitCount + 5'h01;
                    if (bitCount == {2'b00, ADDR_NIBS_QUAD} - 5'h01)
                    begin
                        bitCount <= 5'h00;
                        state <= ST_MODE;
                    end
                end
                ST_MODE:
                begin
                    modeByte <= {modeByte[3:0], io};
                    bitCount <= bitCount + 5'h01;
                    if (bitCount == 5'(MODE_CLOCKS - 1))
                    begin
                        bitCount <= 5'h00;
                        dummyLeft <= dummyTotal - 4'(MODE_CLOCKS);
                        state <= (dummyTotal == 4'(MODE_CLOCKS)) ? ST_DONE : ST_DUMMY;
                    end
                end
                ST_DUMMY:
                begin
                    dummyLeft <= dummyLeft - 4'h1;
                    if (dummyLeft == 4'h1)
                        state <= ST_DONE;
                end
                ST_DONE:
                begin
                    bitCount <= bitCount + 5'h01;
                end
                default: state <= ST_DONE;
            endcase
        end
    end

    // ----------------------------------------
    // quad read setup and continuous mode
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            readSetup <= '0;
            continuousReadMode <= 1'b0;
        end
        else if (sckRise && state == ST_MODE && bitCount == 5'(MODE_CLOCKS - 1))
        begin
            readSetup.addr <= alignedOp ? {addr[23:2], 2'b00} : addr;
            readSetup.dummyClocks <= dummyTotal;
            readSetup.continuousMode <= ({modeByte[3:0], io} & MODE_CONT_MASK) == MODE_CONTINUOUS;
            readSetup.valid <= 1'b1;
            continuousReadMode <= ({modeByte[3:0], io} & MODE_CONT_MASK) == MODE_CONTINUOUS;
        end
        else if (frameEnd)
            readSetup.valid <= 1'b0;
    end

    // ----------------------------------------
    // erase launch, busy timer, write latch
    // ----------------------------------------
    logic eraseCmd;
    logic eraseOk;
    logic weCmd;
    logic [31:0] busyCount;
    logic [23:0] sizeMask;
    assign eraseCmd = opcode == OP_ERASE_4K || opcode == OP_ERASE_32K || opcode == OP_ERASE_64K;
    // byte boundary: bits after the address only in whole bytes
    assign eraseOk = eraseCmd && state == ST_DONE && bitCount[2:0] == 3'h0
                     && writeLatch && !memProtected && !busyFlag;
    assign weCmd = opcode == OP_WRITE_ENABLE && state == ST_DONE && bitCount == 5'h00;
    always_comb
    begin
        unique case (opcode)
            OP_ERASE_4K: sizeMask = MASK_4K;
            OP_ERASE_32K: sizeMask = MASK_32K;
            default: sizeMask = MASK_64K;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            eraseStart <= 1'b0;
            eraseRegion <= '0;
            busyFlag <= 1'b0;
            busyCount <= 32'h00000000;
        end
        else
        begin
            eraseStart <= frameEnd && eraseOk;
            if (frameEnd && eraseOk)
            begin
                eraseRegion.base <= addr & sizeMask;
                eraseRegion.mask <= sizeMask;
                busyFlag <= 1'b1;
                busyCount <= 32'(ERASE_CYCLES_P);
            end
            else if (busyFlag)
            begin
                busyCount <= busyCount - 32'h00000001;
                if (busyCount == 32'h00000001)
                    busyFlag <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            writeLatch <= 1'b0;
        else if (frameEnd && weCmd && !busyFlag)
            writeLatch <= 1'b1;
        else if (frameEnd && eraseCmd)
            writeLatch <= 1'b0;
    end

    always_comb
    begin
        primaryStatusReg = 8'h00;
        primaryStatusReg[BUSY_BIT] = busyFlag;
        primaryStatusReg[LATCH_BIT] = writeLatch;
    end
endmodule
`default_nettype wire

// File: pkg/fdb_pkg.sv
`default_nettype none
package fdb_pkg;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_ERASE_32K = 8'h52;
    localparam logic [7:0] OP_ERASE_64K = 8'hD8;
    localparam logic [7:0] OP_QREAD = 8'hEB;
    localparam logic [7:0] OP_QREAD_ALIGNED = 8'hE7;
    localparam logic [7:0] MODE_CONTINUOUS = 8'hA0;
    localparam logic [7:0] MODE_CONT_MASK = 8'hF0;
    localparam int DUMMY_SEL_MSB = 6;
    localparam int DUMMY_SEL_LSB = 4;
    localparam int ALIGN_BIT = 0;
    localparam int BUSY_BIT = 0;
    localparam int LATCH_BIT = 1;
    localparam int MODE_CLOCKS = 2;
    localparam logic [11:0] ERASE_TIME_US = 12'h064;
    localparam int CLK_MHZ = 50;
    localparam int ERASE_CYCLES = int'(ERASE_TIME_US) * CLK_MHZ;
    localparam logic [23:0] MASK_4K = 24'hFFF000;
    localparam logic [23:0] MASK_32K = 24'hFF8000;
    localparam logic [23:0] MASK_64K = 24'hFF0000;
    localparam logic [4:0] ADDR_BITS_SINGLE = 5'h18;
    localparam logic [2:0] ADDR_NIBS_QUAD = 3'h6;
    localparam logic [3:0] ERASE_LEN_RESET = 4'h0;

    typedef enum logic [1:0]
    {
        FDB_ERASE_4K,
        FDB_ERASE_32K,
        FDB_ERASE_64K
    } fdb_size_t;

    typedef struct packed
    {
        logic [23:0] base;
        logic [23:0] mask;
    } fdb_erase_t;

    typedef struct packed
    {
        logic [23:0] addr;
        logic [3:0] dummyClocks;
        logic continuousMode;
        logic valid;
    } fdb_read_t;
endpackage
`default_nettype wire
